/* File: verilog/ies_exception_seq.sv */
`timescale 1ns/10ps
// ******************************************************
// Instruction exception sequencer
// ******************************************************
module ies_exception_seq
    import ies_pkg::*;
#(
    parameter logic [7:0] SLOT_VEC = 8'h06,    // Illegal-slot vector
    parameter logic [7:0] ILLEGAL_VEC = 8'h04, // General illegal vector
    parameter logic [7:0] AERR_VEC = 8'h09     // Address error vector
) (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    // Decoder and pipeline
    input wire ies_decode_s DEC_IN,
    input wire ies_arch_s ARCH_IN,
    output logic BUSY_OUT,
    // Event sources
    input wire logic AE_EVENT_IN,
    input wire logic IRQ_REQ_IN,
    input wire logic [7:0] IRQ_VEC_IN,
    // Memory bus for stacking and vector fetch
    output logic MEM_REQ_OUT,
    output logic MEM_WE_OUT,
    output logic [31:0] MEM_ADDR_OUT,
    output logic [31:0] MEM_WDATA_OUT,
    input wire logic MEM_ACK_IN,
    input wire logic [31:0] MEM_RDATA_IN,
    input wire logic MEM_AERR_IN,
    // Results back to the pipeline
    output logic DONE_OUT,
    output logic [31:0] NEW_PC_OUT,
    output logic [31:0] NEW_SP_OUT,
    output ies_cause_e CAUSE_OUT
);

    // ******************************************************
    // State
    // ******************************************************
    ies_state_e state;          // Sequencer state
    ies_cause_e cause;          // Cause being processed
    logic ae_pend;              // Held address error
    logic irq_pend;             // Held interrupt
    logic [7:0] irq_vec;        // Vector of the held interrupt
    logic [31:0] ret_pc;        // Return address to push
    logic [31:0] sr_save;       // Status word to push
    logic [31:0] sp_work;       // Stack pointer while stacking
    logic [31:0] vbr_save;      // Vector base for this exception
    logic [7:0] vec_num;        // Vector number for this exception
    logic [31:0] handler;       // Fetched handler address
    logic nested_ae;            // Stacking or vector fetch hit an address error
    logic ae_mute;              // Follow-on address error in progress
    logic req;                  // Bus request flop
    logic we;                   // Bus write flop
    logic [31:0] addr;          // Bus address flop
    logic [31:0] wdata;         // Bus write data flop
    logic done;                 // Completion pulse flop
    logic [31:0] new_pc;        // Handler address to the pipeline
    logic [31:0] new_sp;        // Stack pointer to the pipeline

    // Acceptance windows from the slot tracker
    wire logic in_slot;
    wire logic slot_illegal;
    wire logic [31:0] slot_target;
    wire logic ae_ok;
    wire logic irq_ok;

    ies_accept_gate u_gate (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .dec_in(DEC_IN),
        .idle_in(state == IES_IDLE),
        .in_slot_out(in_slot),
        .slot_illegal_out(slot_illegal),
        .slot_target_out(slot_target),
        .ae_ok_out(ae_ok),
        .irq_ok_out(irq_ok)
    );

    // ******************************************************
    // Start decision for one decode
    // ******************************************************
    wire logic dec_take;        // A decode is looked at
    wire logic ae_now;          // Address error present now
    wire logic irq_now;         // Interrupt present now
    wire logic take_ae;
    wire logic take_irq;
    wire logic take_slot;
    wire logic take_trap;
    wire logic take_ill;
    wire logic start;
    wire logic bus_fault;       // Fault that counts on this cycle

    assign dec_take = DEC_IN.valid & (state == IES_IDLE);
    assign ae_now = ae_pend | AE_EVENT_IN;
    assign irq_now = irq_pend | IRQ_REQ_IN;
    // Held events go in only where the decode allows; see RL9
    assign take_ae = dec_take & ae_now & ae_ok;
    assign take_irq = dec_take & irq_now & irq_ok & ~take_ae;
    // A slot instruction never yields to a pending event
    assign take_slot = dec_take & slot_illegal & ~take_ae & ~take_irq;
    assign take_trap = dec_take & ~in_slot & DEC_IN.trap &
        ~take_ae & ~take_irq;
    assign take_ill = dec_take & ~in_slot & DEC_IN.undef &
        ~take_ae & ~take_irq; // see RL6
    assign start = take_ae | take_irq | take_slot | take_trap | take_ill;
    // During a follow-on address error further faults are dropped
    assign bus_fault = MEM_ACK_IN & MEM_AERR_IN & ~ae_mute; // see RL15

    // Selected return address and vector for a fresh start
    wire logic [31:0] start_pc;
    wire logic [7:0] start_vec;
    wire ies_cause_e start_cause;

    // Interrupt and address error replace the decoded instruction,
    // so its address is the one after the last executed
    assign start_pc = take_slot ? slot_target : // see RL5
        take_trap ? DEC_IN.next_addr : // see RL1
        DEC_IN.instr_addr; // see RL6 see RL8
    assign start_vec = take_ae ? AERR_VEC :
        take_irq ? (IRQ_REQ_IN & ~irq_pend ? IRQ_VEC_IN : irq_vec) :
        take_slot ? SLOT_VEC :
        take_trap ? DEC_IN.trap_vec : // see RL2
        ILLEGAL_VEC;
    assign start_cause = take_ae ? IES_CAUSE_ADDR_ERR :
        take_irq ? IES_CAUSE_IRQ :
        take_slot ? IES_CAUSE_SLOT :
        take_trap ? IES_CAUSE_TRAP : IES_CAUSE_ILLEGAL;

    // ******************************************************
    // Held events
    // ******************************************************
    // A new event in the acceptance cycle stays held: set wins
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ae_pend <= 1'b0;
            irq_pend <= 1'b0;
            irq_vec <= IES_VEC_RST;
        end else begin
            ae_pend <= (ae_pend & ~take_ae) | AE_EVENT_IN; // see RL9
            irq_pend <= (irq_pend & ~take_irq) | IRQ_REQ_IN; // see RL9
            if (IRQ_REQ_IN) begin
                irq_vec <= IRQ_VEC_IN;
            end
        end
    end

    // ******************************************************
    // Next-state selection
    // ******************************************************
    wire logic ae_follow;       // Follow-on address error to run
    wire logic [31:0] sp_dec;   // One push below the working pointer

    assign ae_follow = (state == IES_FINISH) & nested_ae;
    assign sp_dec = sp_work - IES_STACK_STEP; // see RL16

    // Bus transfers: status first at higher word, then return address
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state <= IES_IDLE;
            req <= 1'b0;
            we <= 1'b0;
            addr <= IES_WORD_RST;
            wdata <= IES_WORD_RST;
        end else begin
            unique case (state)
                IES_IDLE: begin
                    if (start) begin
                        // Address is the decremented pointer, even if odd
                        state <= IES_PUSH_SR;
                        req <= 1'b1;
                        we <= 1'b1;
                        addr <= ARCH_IN.stack_pointer -
                            IES_STACK_STEP; // see RL7 see RL16
                        wdata <= ARCH_IN.status_register; // see RL1
                    end
                end
                IES_PUSH_SR: begin
                    if (MEM_ACK_IN) begin
                        state <= IES_PUSH_PC;
                        addr <= sp_dec; // see RL7
                        wdata <= ret_pc; // see RL1
                    end
                end
                IES_PUSH_PC: begin
                    if (MEM_ACK_IN) begin
                        state <= IES_FETCH_VEC;
                        we <= 1'b0;
                        addr <= ies_vec_addr(vbr_save, vec_num); // see RL17
                    end
                end
                IES_FETCH_VEC: begin
                    if (MEM_ACK_IN) begin
                        state <= IES_FINISH;
                        req <= 1'b0;
                    end
                end
                IES_FINISH: begin
                    // Chain straight into the address error processing
                    if (ae_follow) begin
                        state <= IES_PUSH_SR; // see RL14
                        req <= 1'b1;
                        we <= 1'b1;
                        addr <= sp_dec;
                        wdata <= sr_save;
                    end else begin
                        state <= IES_IDLE;
                    end
                end
            endcase
        end
    end

    // ******************************************************
    // Exception context
    // ******************************************************
    // Captured at start; the follow-on keeps status and stack
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cause <= IES_CAUSE_NONE;
            ret_pc <= IES_WORD_RST;
            sr_save <= IES_WORD_RST;
            vbr_save <= IES_WORD_RST;
            vec_num <= IES_VEC_RST;
            ae_mute <= 1'b0;
        end else if (start) begin
            cause <= start_cause;
            ret_pc <= start_pc;
            sr_save <= ARCH_IN.status_register;
            vbr_save <= ARCH_IN.vector_base_register;
            vec_num <= start_vec;
            ae_mute <= 1'b0;
        end else if (ae_follow) begin
            // Return to where the first handler would have started
            cause <= IES_CAUSE_ADDR_ERR;
            ret_pc <= handler; // see RL14
            vec_num <= AERR_VEC;
            ae_mute <= 1'b1; // see RL15
        end else if (state == IES_FINISH) begin
            ae_mute <= 1'b0;
        end
    end

    // Working pointer drops four for each push; see RL7
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sp_work <= IES_WORD_RST;
        end else if (start) begin
            sp_work <= ARCH_IN.stack_pointer - IES_STACK_STEP;
        end else if (ae_follow) begin
            sp_work <= sp_dec;
        end else if ((state == IES_PUSH_SR) && MEM_ACK_IN) begin
            sp_work <= sp_dec; // see RL16
        end
    end

    // Faults during stacking or vector fetch; a misaligned stack or
    // vector base shows up here as a bus fault (see RL12, RL13)
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            nested_ae <= 1'b0;
            handler <= IES_WORD_RST;
        end else begin
            if (start || ae_follow) begin
                nested_ae <= 1'b0;
            end else if (bus_fault && state != IES_IDLE) begin
                nested_ae <= 1'b1; // see RL14
            end
            if ((state == IES_FETCH_VEC) && MEM_ACK_IN) begin
                handler <= MEM_RDATA_IN; // see RL2
            end
        end
    end

    // ******************************************************
    // Results
    // ******************************************************
    // Handler jump is direct, with no delay slot unless an event replaced a delayed branch
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            done <= 1'b0;
            new_pc <= IES_WORD_RST;
            new_sp <= IES_WORD_RST;
        end else begin
            done <= (state == IES_FINISH) & ~nested_ae; // see RL2
            if ((state == IES_FINISH) && !nested_ae) begin
                new_pc <= handler;
                new_sp <= sp_work; // see RL7
            end
        end
    end

    assign BUSY_OUT = (state != IES_IDLE);
    assign MEM_REQ_OUT = req;
    assign MEM_WE_OUT = we;
    assign MEM_ADDR_OUT = addr;
    assign MEM_WDATA_OUT = wdata;
    assign DONE_OUT = done;
    assign NEW_PC_OUT = new_pc;
    assign NEW_SP_OUT = new_sp;
    assign CAUSE_OUT = cause;

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    a_trap_push_order: assert property ( // see RL1
        take_trap |=> (state == IES_PUSH_SR && we && wdata == sr_save
            && ret_pc == $past(DEC_IN.next_addr)))
        else $error("trap stacking start wrong");
    a_trap_vector_addr: assert property ( // see RL2
        (state == IES_PUSH_PC && MEM_ACK_IN) |=>
            addr == ies_vec_addr(vbr_save, vec_num) && !we)
        else $error("vector fetch address wrong");
    a_slot_start: assert property ( // see RL3
        (dec_take && slot_illegal && !ae_now) |=>
            cause == IES_CAUSE_SLOT)
        else $error("slot exception not started");
    a_slot_pc_rewrite: assert property ( // see RL4
        (dec_take && in_slot && DEC_IN.pc_rewrite) |=>
            state == IES_PUSH_SR)
        else $error("pc rewrite in slot not caught");
    a_slot_ret_pc: assert property ( // see RL5
        take_slot |=> ret_pc == $past(slot_target))
        else $error("slot return address wrong");
    a_illegal_ret_pc: assert property ( // see RL6
        take_ill |=> ret_pc == $past(DEC_IN.instr_addr))
        else $error("illegal return address wrong");
    a_pc_push_below_sr: assert property ( // see RL7
        (state == IES_PUSH_SR && MEM_ACK_IN) |=>
            addr == $past(addr) - IES_STACK_STEP && wdata == ret_pc)
        else $error("return address not one word below");
    a_irq_ret_pc: assert property ( // see RL8
        take_irq |=> ret_pc == $past(DEC_IN.instr_addr))
        else $error("interrupt return address wrong");
    a_irq_held: assert property ( // see RL9
        (IRQ_REQ_IN && !take_irq) |=> irq_pend)
        else $error("refused interrupt lost");
    a_slot_no_events: assert property ( // see RL10
        (dec_take && in_slot) |-> !take_ae && !take_irq)
        else $error("event taken in delay slot");
    a_follow_on_chain: assert property ( // see RL14
        (state == IES_FINISH && nested_ae) |=>
            state == IES_PUSH_SR && cause == IES_CAUSE_ADDR_ERR)
        else $error("follow-on address error missing");
    a_mute_no_nest: assert property ( // see RL15
        (ae_mute && state == IES_FETCH_VEC && MEM_ACK_IN) |=>
            !nested_ae)
        else $error("address error loop");
    a_done_sp: assert property ( // see RL16
        done |-> new_sp == $past(sp_work, 1))
        else $error("final stack pointer wrong");

    c_trap: cover property (take_trap ##[1:40] done);
    c_slot: cover property (take_slot ##[1:40] done);
    c_irq_deferred: cover property (irq_now && in_slot && dec_take);
    c_nested: cover property (ae_follow ##[1:40] done);

endmodule : ies_exception_seq

/* File: verilog/ies_pkg.sv */
// What this block does
// RL1: Trap pushes status, then next address
// RL2: Trap vector from instruction, no delay slot
// RL3: Undefined opcode in slot raises slot exception
// RL4: PC-rewriting instruction in slot also illegal
// RL5: Slot exception pushes preceding branch target
// RL6: Undefined opcode elsewhere pushes own address
// RL7: Two words pushed, stack points at return
// RL8: Interrupt pushes address after last executed
// RL9: Refused events held until decode permits
// RL10: Slot decode refuses address errors, interrupts
// RL11: After register load/store, refuse interrupts only
// RL12: Software keeps stack pointer word aligned
// RL13: Software keeps vector base word aligned
// RL14: Stacking address error follows first exception
// RL15: Follow-on stacking ignores further address errors
// RL16: Misaligned pushes still issued, four each
// RL17: Vector entry at base plus four times number
package ies_pkg;

    // ******************************************************
    // Widths, steps and reset values
    // ******************************************************
    localparam int IES_XLEN = 32;               // Data and address width
    localparam int IES_VEC_W = 8;               // Vector number width
    localparam logic [31:0] IES_STACK_STEP = 32'h0000_0004; // One push
    localparam int IES_VEC_SHIFT = 2;           // Entry is one word
    localparam logic [31:0] IES_WORD_RST = 32'h0000_0000; // Reset value
    localparam logic [7:0] IES_VEC_RST = 8'h00; // Reset vector number

    // ******************************************************
    // Carriers
    // ******************************************************
    // One decoded instruction as the decoder presents it
    typedef struct packed {
        logic valid;                // A decode happens this cycle
        logic undef;                // Undefined opcode
        logic pc_rewrite;           // Branch, jump, return or trap
        logic delayed_branch;       // Has a delay slot after it
        logic ctrl_ldst;            // Control or system reg load/store
        logic trap;                 // Trap-always instruction
        logic [7:0] trap_vec;       // Vector number in the trap
        logic [31:0] instr_addr;    // Address of this instruction
        logic [31:0] next_addr;     // Address of the one after it
        logic [31:0] branch_target; // Target of a delayed branch
    } ies_decode_s;

    // Architectural state handed in from the pipeline
    typedef struct packed {
        logic [31:0] status_register;
        logic [31:0] stack_pointer;
        logic [31:0] vector_base_register;
    } ies_arch_s;

    // What started the current exception
    typedef enum logic [2:0] {
        IES_CAUSE_NONE,
        IES_CAUSE_TRAP,
        IES_CAUSE_SLOT,
        IES_CAUSE_ILLEGAL,
        IES_CAUSE_ADDR_ERR,
        IES_CAUSE_IRQ
    } ies_cause_e;

    // Sequencer states
    typedef enum logic [2:0] {
        IES_IDLE,
        IES_PUSH_SR,
        IES_PUSH_PC,
        IES_FETCH_VEC,
        IES_FINISH
    } ies_state_e;

    // Vector table entry address
    function automatic logic [31:0] ies_vec_addr(
        input logic [31:0] base,
        input logic [7:0] vec
    );
        ies_vec_addr = base + ({24'h00_0000, vec} << IES_VEC_SHIFT);
    endfunction : ies_vec_addr

endpackage : ies_pkg

/* File: verilog/ies_accept_gate.sv */
`timescale 1ns/10ps
// ******************************************************
// Delay-slot tracking and acceptance windows
// ******************************************************
module ies_accept_gate
    import ies_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Decode stream, only looked at while the sequencer idles
    input wire ies_decode_s dec_in,
    input wire logic idle_in,
    // Acceptance results for this decode
    output logic in_slot_out,
    output logic slot_illegal_out,
    output logic [31:0] slot_target_out,
    output logic ae_ok_out,
    output logic irq_ok_out
);

    logic slot_armed;          // Next decode is a delay slot
    logic after_ldst;          // Next decode follows a reg load/store
    logic [31:0] held_target;  // Target of the branch owning the slot
    wire logic taking;         // A decode counts this cycle

    assign taking = dec_in.valid & idle_in;

    // Slot state follows each accepted decode only; an exception does not clear it
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slot_armed <= 1'b0;
            after_ldst <= 1'b0;
            held_target <= IES_WORD_RST;
        end else if (taking) begin
            slot_armed <= dec_in.delayed_branch & ~slot_armed;
            after_ldst <= dec_in.ctrl_ldst;
            if (dec_in.delayed_branch) begin
                held_target <= dec_in.branch_target;
            end
        end
    end

    assign in_slot_out = slot_armed;
    assign slot_target_out = held_target; // see RL5
    // Undefined code or any PC rewrite in the slot is illegal
    assign slot_illegal_out = slot_armed &
        (dec_in.undef | dec_in.pc_rewrite); // see RL3 see RL4
    // Slot decode refuses both; after reg load/store only interrupts
    assign ae_ok_out = ~slot_armed; // see RL10
    assign irq_ok_out = ~slot_armed & ~after_ldst; // see RL10 see RL11

    // ******************************************************
    // Checks
    // ******************************************************
    a_slot_blocks_all: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        slot_armed |-> (!ae_ok_out && !irq_ok_out)) // see RL10
        else $error("event window open during delay slot");
    a_ldst_keeps_ae: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        (taking && dec_in.ctrl_ldst && !slot_armed)
        |=> (!irq_ok_out && ae_ok_out)) // see RL11
        else $error("load/store window wrong");

endmodule : ies_accept_gate

/* File: test/ies_mem_model.sv */
`timescale 1ns/10ps
// ********************************************
// Memory bus partner for stacking and vectors
// ********************************************
module ies_mem_model
    import ies_pkg::*;
(
    // Clock, answer speed and log control
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic clr_in,
    // Request side
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    // Answer side
    output logic ack_out = 1'b0,
    output logic [31:0] rdata_out = 32'h0000_0000,
    output logic aerr_out = 1'b0
);
    logic [31:0] log_a [8]; // Transfer addresses in order
    logic [31:0] log_d [8]; // Write data or read data handed out
    int n = 0; // Transfers logged
    int wait_c = 0; // Cycles the current transfer has waited
    // Answer each transfer at once or after a few cycles
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        aerr_out <= 1'b0;
        // Read data changes every cycle outside an answer
        rdata_out <= ~rdata_out;
        if (clr_in) begin
            n = 0;
        end else if (req_in && !ack_out) begin
            wait_c = wait_c + 1;
            // Slow mode stalls so that held requests are exercised
            if (!slow_in || wait_c > 3) begin
                wait_c = 0;
                ack_out <= 1'b1;
                aerr_out <= (addr_in[1:0] != 2'b00);
                rdata_out <= ~addr_in;
                log_a[n % 8] = addr_in;
                log_d[n % 8] = we_in ? wdata_in : ~addr_in;
                n = n + 1;
            end
        end
    end
endmodule : ies_mem_model

/* File: test/instruction_exception_sequencer_tb_top.sv */
`timescale 1ns/10ps
module instruction_exception_sequencer_tb_top;
    import ies_pkg::*;
    // Vector numbers handed to the design
    localparam logic [7:0] slot_vec = 8'h06;
    localparam logic [7:0] illegal_vec = 8'h04;
    localparam logic [7:0] aerr_vec = 8'h09;
    logic sys_clk = 1'b0, rstn = 1'b0, slow = 1'b0, clr = 1'b0;
    logic irq = 1'b0, ae = 1'b0, busy, req, we, ack, aerr, done;
    logic [7:0] ivec = 8'h00;
    logic [31:0] addr, wdata, rdata, npc, nsp, t, s;
    logic [31:0] seed = 32'h0000_3c9c; // Start value of the generator
    ies_decode_s dec = '0, d;
    ies_arch_s arch = '0;
    ies_cause_e cause;
    int n_mismatch = 0, tests_run = 0;
    always #50 sys_clk = ~sys_clk;
    ies_exception_seq #(.SLOT_VEC(slot_vec), .ILLEGAL_VEC(illegal_vec),
        .AERR_VEC(aerr_vec)) dut (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn),
        .DEC_IN(dec), .ARCH_IN(arch), .BUSY_OUT(busy), .AE_EVENT_IN(ae),
        .IRQ_REQ_IN(irq), .IRQ_VEC_IN(ivec), .MEM_REQ_OUT(req),
        .MEM_WE_OUT(we), .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata),
        .MEM_ACK_IN(ack), .MEM_RDATA_IN(rdata), .MEM_AERR_IN(aerr),
        .DONE_OUT(done), .NEW_PC_OUT(npc), .NEW_SP_OUT(nsp),
        .CAUSE_OUT(cause));
    ies_mem_model mem (.clk_in(sys_clk), .slow_in(slow), .clr_in(clr),
        .req_in(req), .we_in(we), .addr_in(addr), .wdata_in(wdata),
        .ack_out(ack), .rdata_out(rdata), .aerr_out(aerr));
    // Xorshift generator, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Ordinary instruction at a random even address
    function automatic ies_decode_s plain();
        ies_decode_s p;
        p = '0;
        p.valid = 1'b1;
        p.instr_addr = rnd() & 32'hffff_fffe;
        p.next_addr = p.instr_addr + 32'h2;
        return p;
    endfunction : plain
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One decode pulse; the log is cleared with it
    task decode(input ies_decode_s x);
        @(negedge sys_clk);
        dec = x;
        clr = 1'b1;
        @(negedge sys_clk);
        dec.valid = 1'b0;
        clr = 1'b0;
    endtask : decode
    task give_verdict();
        $display("mismatches %0d in %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Bounded wait for the completion pulse
    task wait_done();
        int i;
        i = 0;
        while (done !== 1'b1 && i < 300) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i >= 300) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_done
    task expect_exc(input logic [31:0] ret, input logic [7:0] v,
                    input ies_cause_e c);
        logic [31:0] ent;
        ent = arch.vector_base_register + {22'h0, v, 2'b00};
        wait_done();
        s = arch.stack_pointer;
        chk("sr addr", s - 32'h4, mem.log_a[0]);
        chk("sr data", arch.status_register, mem.log_d[0]);
        chk("pc addr", s - 32'h8, mem.log_a[1]);
        chk("pc data", ret, mem.log_d[1]);
        chk("vector addr", ent, mem.log_a[2]);
        chk("new pc", ~ent, npc);
        chk("new sp", s - 32'h8, nsp);
        chk("cause", {29'h0, c}, {29'h0, cause});
    endtask : expect_exc
    // Main sequence: random traps, then the corner cases
    initial begin
        repeat (4) @(negedge sys_clk);
        chk("reset busy", 32'h0, {31'h0, busy});
        rstn = 1'b1;
        for (int k = 0; k < 6; k++) begin
            arch = {rnd(), rnd() & ~32'h3, rnd() & ~32'h3};
            slow = ^rnd();
            d = plain();
            d.trap = 1'b1;
            d.pc_rewrite = 1'b1;
            d.trap_vec = 8'(rnd());
            decode(d);
            expect_exc(d.next_addr, d.trap_vec, IES_CAUSE_TRAP);
        end
        // Slot holding undefined code, then a trap in the slot
        for (int k = 0; k < 2; k++) begin
            d = plain();
            d.delayed_branch = 1'b1;
            d.pc_rewrite = 1'b1;
            d.branch_target = rnd() & ~32'h1;
            t = d.branch_target;
            decode(d);
            d = plain();
            d.undef = (k == 0);
            d.pc_rewrite = (k == 1);
            d.trap = (k == 1);
            decode(d);
            expect_exc(t, slot_vec, IES_CAUSE_SLOT);
        end
        d = plain();
        d.undef = 1'b1;
        decode(d);
        expect_exc(d.instr_addr, illegal_vec, IES_CAUSE_ILLEGAL);
        // Events refused in a slot and after a register load/store
        for (int k = 0; k < 3; k++) begin
            d = plain();
            d.delayed_branch = (k != 1);
            d.ctrl_ldst = (k == 1);
            decode(d);
            @(negedge sys_clk);
            irq = (k < 2);
            ae = (k == 2);
            ivec = 8'(rnd());
            @(negedge sys_clk);
            irq = 1'b0;
            ae = 1'b0;
            decode(plain());
            chk("busy refused", 32'h0, {31'h0, busy});
            d = plain();
            decode(d);
            expect_exc(d.instr_addr, k < 2 ? ivec : aerr_vec,
                k < 2 ? IES_CAUSE_IRQ : IES_CAUSE_ADDR_ERR);
        end
        // Misaligned stack: chained address error, no endless loop
        arch.stack_pointer = arch.stack_pointer | 32'h2;
        d = plain();
        d.undef = 1'b1;
        decode(d);
        wait_done();
        s = arch.stack_pointer;
        t = arch.vector_base_register + 32'h24;
        chk("bad push", s - 32'h4, mem.log_a[0]);
        chk("chain sr addr", s - 32'hc, mem.log_a[3]);
        chk("chain pc addr", s - 32'h10, mem.log_a[4]);
        chk("chain vector", t, mem.log_a[5]);
        chk("chain new pc", ~t, npc);
        chk("chain new sp", s - 32'h10, nsp);
        chk("chain cause", 32'(IES_CAUSE_ADDR_ERR), 32'(cause));
        give_verdict();
    end
endmodule : instruction_exception_sequencer_tb_top
